/* File: hdl/usb_line_termination_decoder.sv */
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "usb_line_termination_cfg.svh"

// Overview of operation
// - pull-up enable connects the plus-line pull-up; deasserted disconnects it.
// - plus-line pull-down enable connects that line's pull-down resistor.
// - minus-line pull-down enable connects that line's pull-down resistor.
// - termination enable connects the high-speed terminations on both lines.
// - non-driving operating mode forces all four enables off.
// - otherwise each pull-down enable follows its own request bit.
// - termination on exactly when not non-driving, speed select is high-speed and termination select clear.
// - pull-up on only with termination select set and plus pull-down clear.
// - host chirp gives both pull-downs and termination, no pull-up.
// - host suspend gives only the two pull-downs.
// - host resume gives only the two pull-downs.
// - host test J or K matches the host chirp pattern.
// - register writes from the link update the state bits.

module usb_line_termination_decoder
    import usb_line_termination_pkg::*;
(
    input wire logic clk, // 10 mhz system clock
    input wire logic reset_n, // synchronous reset, active low
    input wire apb_req_type apb_req, // apb request from the link side
    output apb_rsp_type apb_rsp, // apb answer
    output resistor_en_type res_en, // resistor enables to the front end
    output line_ctrl_type ctrl_bits, // current state bits for other blocks
    output logic settings_changed // one-cycle pulse after a bus write changes the value; none when reset reloads it
);

    // ****************************************************************
    // register index decode
    // ****************************************************************
    localparam logic [2:0] idx_ctrl = 3'h0;
    localparam logic [2:0] idx_set = 3'h1;
    localparam logic [2:0] idx_clr = 3'h2;
    localparam logic [2:0] idx_status = 3'h3;
    localparam logic [2:0] idx_count = 3'h4;
    localparam logic [2:0] idx_none = 3'h7;

    // used for both the read capture and the write commit
    function automatic logic [2:0] reg_index(input logic [11:0] addr);
        logic [2:0] i;
        i = idx_none;
        case (addr)
            `LT_CTRL_OFFSET: i = idx_ctrl;
            `LT_CTRL_SET_OFFSET: i = idx_set;
            `LT_CTRL_CLR_OFFSET: i = idx_clr;
            `LT_STATUS_OFFSET: i = idx_status;
            `LT_COUNT_OFFSET: i = idx_count;
            default: i = idx_none;
        endcase
        return i;
    endfunction : reg_index

    // ****************************************************************
    // field packing between the bus word and the struct
    // ****************************************************************
    function automatic line_ctrl_type ctrl_from_word(input logic [6:0] w);
        line_ctrl_type c;
        c.transceiver_speed_select = w[`LT_XCVR_MSB:`LT_XCVR_LSB];
        c.termination_select = w[`LT_TERM_BIT];
        c.operating_mode_sel = w[`LT_OPERATING_MODE_SEL_MSB:`LT_OPERATING_MODE_SEL_LSB];
        c.plus_line_pull_low_req = w[`LT_DP_REQ_BIT];
        c.minus_line_pull_low_req = w[`LT_DM_REQ_BIT];
        return c;
    endfunction : ctrl_from_word

    function automatic logic [6:0] word_from_ctrl(input line_ctrl_type c);
        logic [6:0] w;
        w = '0;
        w[`LT_XCVR_MSB:`LT_XCVR_LSB] = c.transceiver_speed_select;
        w[`LT_TERM_BIT] = c.termination_select;
        w[`LT_OPERATING_MODE_SEL_MSB:`LT_OPERATING_MODE_SEL_LSB] = c.operating_mode_sel;
        w[`LT_DP_REQ_BIT] = c.plus_line_pull_low_req;
        w[`LT_DM_REQ_BIT] = c.minus_line_pull_low_req;
        return w;
    endfunction : word_from_ctrl

    // ****************************************************************
    // module state
    // ****************************************************************
    typedef struct packed {
        logic [6:0] ctrl_word;
        logic [31:0] prdata;
        logic pslverr;
        logic changed;
        logic [15:0] write_count;
    } top_state_type;

    top_state_type state_reg;
    top_state_type state_next;

    line_ctrl_type ctrl_now;
    line_role_type role_now;
    logic nondriving_now;
    resistor_en_type res_now;
    logic setup_phase;
    logic access_done;
    logic [2:0] setup_idx;
    logic [2:0] access_idx;
    logic lane0;
    logic [6:0] wr_bits;
    logic [6:0] ctrl_new;
    logic [31:0] status_word;

    // ****************************************************************
    // resistor decode
    // ****************************************************************
    assign ctrl_now = ctrl_from_word(state_reg.ctrl_word);

    // decode sits straight on the flops
    line_resistor_decode u_decode (
        .ctrl(ctrl_now),
        .res_en(res_now),
        .role(role_now),
        .nondriving(nondriving_now)
    );

    // ****************************************************************
    // bus phase tracking
    // ****************************************************************
    assign setup_phase = apb_req.psel && !apb_req.penable;
    // zero wait states, so every access cycle completes
    assign access_done = apb_req.psel && apb_req.penable;
    assign setup_idx = reg_index(apb_req.paddr);
    assign access_idx = reg_index(apb_req.paddr);
    // control fields live in byte lane 0 only
    assign lane0 = apb_req.pstrb[0];
    assign wr_bits = apb_req.pwdata[6:0];

    // status word gathers the live enables and the role
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`LT_ST_PULLUP_BIT] = res_now.plus_line_pullup_on;
        status_word[`LT_ST_DP_PD_BIT] = res_now.plus_line_pulldown_on;
        status_word[`LT_ST_DM_PD_BIT] = res_now.minus_line_pulldown_on;
        status_word[`LT_ST_HSTERM_BIT] = res_now.high_speed_termination_on;
        status_word[`LT_ST_ROLE_MSB:`LT_ST_ROLE_LSB] = role_now;
        status_word[`LT_ST_NONDRIVE_BIT] = nondriving_now;
    end

    // ****************************************************************
    // write merge: plain write, set and clear aliases
    // ****************************************************************
    // set and clear let the link touch one bit without a read first
    always_comb begin
        ctrl_new = state_reg.ctrl_word;
        if (access_done && apb_req.pwrite && lane0) begin
            case (access_idx)
                idx_ctrl: ctrl_new = wr_bits;
                idx_set: ctrl_new = state_reg.ctrl_word | wr_bits;
                idx_clr: ctrl_new = state_reg.ctrl_word & ~wr_bits;
                default: ctrl_new = state_reg.ctrl_word;
            endcase
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.changed = 1'b0;
        // only bus writes and reset move the bits, nothing else here alters them
        state_next.ctrl_word = ctrl_new;
        if (ctrl_new != state_reg.ctrl_word) begin
            state_next.changed = 1'b1;
        end
        if (access_done && apb_req.pwrite && lane0
            && (access_idx == idx_ctrl || access_idx == idx_set || access_idx == idx_clr)) begin
            // counter wraps; software compares differences
            state_next.write_count = state_reg.write_count + 16'h0001;
        end
        // read data and error are taken in setup so they come from flops
        if (setup_phase) begin
            state_next.prdata = 32'h0000_0000;
            state_next.pslverr = 1'b0;
            case (setup_idx)
                idx_ctrl: state_next.prdata = {25'h0000000, state_reg.ctrl_word};
                idx_set: state_next.prdata = {25'h0000000, state_reg.ctrl_word};
                idx_clr: state_next.prdata = {25'h0000000, state_reg.ctrl_word};
                idx_status: begin
                    state_next.prdata = status_word;
                    state_next.pslverr = apb_req.pwrite;
                end
                idx_count: begin
                    state_next.prdata = {16'h0000, state_reg.write_count};
                    state_next.pslverr = apb_req.pwrite;
                end
                default: state_next.pslverr = 1'b1;
            endcase
        end
        if (!reset_n) begin
            state_next.ctrl_word = `LT_CTRL_RESET;
            state_next.prdata = 32'h0000_0000;
            state_next.pslverr = 1'b0;
            state_next.changed = 1'b0;
            state_next.write_count = `LT_COUNT_RESET;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // read data shown only while the access phase runs
    always_comb begin
        apb_rsp.pready = 1'b1;
        apb_rsp.prdata = access_done ? state_reg.prdata : 32'h0000_0000;
        apb_rsp.pslverr = access_done && state_reg.pslverr;
    end

    assign res_en = res_now;
    assign ctrl_bits = ctrl_now;
    assign settings_changed = state_reg.changed;

endmodule : usb_line_termination_decoder

/* File: inc/usb_line_termination_cfg.svh */
`ifndef USB_LINE_TERMINATION_CFG_SVH
`define USB_LINE_TERMINATION_CFG_SVH

// ****************************************************************
// register byte offsets on the apb bus
// ****************************************************************
`define LT_ADDR_WIDTH 12
`define LT_CTRL_OFFSET 12'h000
`define LT_CTRL_SET_OFFSET 12'h004
`define LT_CTRL_CLR_OFFSET 12'h008
`define LT_STATUS_OFFSET 12'h00C
`define LT_COUNT_OFFSET 12'h010

// ****************************************************************
// control register field positions
// ****************************************************************
`define LT_XCVR_LSB 0
`define LT_XCVR_MSB 1
`define LT_TERM_BIT 2
`define LT_OPERATING_MODE_SEL_LSB 3
`define LT_OPERATING_MODE_SEL_MSB 4
`define LT_DP_REQ_BIT 5
`define LT_DM_REQ_BIT 6
`define LT_CTRL_WIDTH 7

// ****************************************************************
// status register field positions
// ****************************************************************
`define LT_ST_PULLUP_BIT 0
`define LT_ST_DP_PD_BIT 1
`define LT_ST_DM_PD_BIT 2
`define LT_ST_HSTERM_BIT 3
`define LT_ST_ROLE_LSB 4
`define LT_ST_ROLE_MSB 6
`define LT_ST_NONDRIVE_BIT 7

// ****************************************************************
// reset values and field codes
// ****************************************************************
`define LT_CTRL_RESET 7'h61
`define LT_OPERATING_MODE_SEL_NONDRIVING 2'h1
`define LT_XCVR_HIGH_SPEED 2'h0
`define LT_COUNT_RESET 16'h0000

`endif

/* File: inc/usb_line_termination_pkg.sv */
package usb_line_termination_pkg;

    // ****************************************************************
    // state control bits as the link programs them
    // ****************************************************************
    typedef struct packed {
        logic minus_line_pull_low_req;
        logic plus_line_pull_low_req;
        logic [1:0] operating_mode_sel;
        logic termination_select;
        logic [1:0] transceiver_speed_select;
    } line_ctrl_type;

    // ****************************************************************
    // resistor enables towards the analog front end
    // ****************************************************************
    typedef struct packed {
        logic high_speed_termination_on;
        logic minus_line_pulldown_on;
        logic plus_line_pulldown_on;
        logic plus_line_pullup_on;
    } resistor_en_type;

    // ****************************************************************
    // coarse role implied by the operating mode and the pull-down requests
    // ****************************************************************
    typedef enum logic [2:0] {
        role_nondriving = 3'b000,
        role_host = 3'b001,
        role_peripheral = 3'b010,
        role_otg_peripheral = 3'b011,
        role_unusual = 3'b100
    } line_role_type;

    // ****************************************************************
    // apb carriers
    // ****************************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_type;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } apb_rsp_type;

endpackage : usb_line_termination_pkg

/* File: hdl/line_resistor_decode.sv */
`timescale 1ns/1ns
`include "usb_line_termination_cfg.svh"

// pure decode of the state bits into resistor enables
module line_resistor_decode
    import usb_line_termination_pkg::*;
(
    input wire line_ctrl_type ctrl, // registered state control bits
    output resistor_en_type res_en, // resistor enables
    output line_role_type role, // coarse role for status
    output logic nondriving // drivers three-stated
);

    // ****************************************************************
    // role classification
    // ****************************************************************
    function automatic line_role_type role_of(input line_ctrl_type c);
        line_role_type r;
        r = role_unusual;
        if (c.operating_mode_sel == `LT_OPERATING_MODE_SEL_NONDRIVING) begin
            r = role_nondriving;
        end else begin
            case ({c.plus_line_pull_low_req, c.minus_line_pull_low_req})
                2'h3: r = role_host;
                2'h0: r = role_peripheral;
                2'h1: r = role_otg_peripheral;
                default: r = role_unusual;
            endcase
        end
        return r;
    endfunction : role_of

    // ****************************************************************
    // resistor pattern
    // ****************************************************************
    // no clock here so a new setting reaches the pins in the same cycle
    always_comb begin
        nondriving = (ctrl.operating_mode_sel == `LT_OPERATING_MODE_SEL_NONDRIVING);
        role = role_of(ctrl);
        res_en = '0;
        if (!nondriving) begin
            res_en.plus_line_pulldown_on = ctrl.plus_line_pull_low_req;
            res_en.minus_line_pulldown_on = ctrl.minus_line_pull_low_req;
            res_en.high_speed_termination_on = (ctrl.transceiver_speed_select == `LT_XCVR_HIGH_SPEED)
                && !ctrl.termination_select;
            // the plus-line pull-down request always vetoes the pull-up
            res_en.plus_line_pullup_on = ctrl.termination_select && !ctrl.plus_line_pull_low_req;
        end
    end

endmodule : line_resistor_decode

/* File: tb/line_term_assertions.sv */
`timescale 1ns/1ns
// ********
// resistor decode checker
// ********
module line_term_checker
    import usb_line_termination_pkg::*;
(
    input wire logic clk, // bus clock
    input wire logic reset_n, // sync reset, low
    input wire apb_req_type apb_req, // apb request
    input wire apb_rsp_type apb_rsp, // apb answer
    input wire resistor_en_type res_en, // resistor enables
    input wire line_ctrl_type ctrl_bits, // state bits
    input wire logic settings_changed // change pulse
);
    logic acc_wr;
    logic drv;
    logic [6:0] wd;
    // committed write, driving mode and low data bits
    assign acc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign drv = ctrl_bits.operating_mode_sel != 2'b01;
    assign wd = apb_req.pwdata[6:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_nondrive; !drv |-> res_en == '0; endproperty
    a_nondrive: assert property (p_nondrive) else $error("enable on in nondriving mode");
    property p_pullup;
        res_en.plus_line_pullup_on == (drv && ctrl_bits.termination_select && !ctrl_bits.plus_line_pull_low_req);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up enable wrong");
    property p_plus_pd; res_en.plus_line_pulldown_on == (drv && ctrl_bits.plus_line_pull_low_req); endproperty
    a_plus_pd: assert property (p_plus_pd) else $error("plus pull-down wrong");
    property p_minus_pd; res_en.minus_line_pulldown_on == (drv && ctrl_bits.minus_line_pull_low_req); endproperty
    a_minus_pd: assert property (p_minus_pd) else $error("minus pull-down wrong");
    property p_hsterm;
        res_en.high_speed_termination_on ==
            (drv && ctrl_bits.transceiver_speed_select == 2'b00 && !ctrl_bits.termination_select);
    endproperty
    a_hsterm: assert property (p_hsterm) else $error("termination enable wrong");
    // a plain write lands on the next cycle
    property p_write; acc_wr && apb_req.paddr == 12'h000 && apb_req.pstrb[0] |=> ctrl_bits == $past(wd); endproperty
    a_write: assert property (p_write) else $error("control write lost");
    property p_set;
        acc_wr && apb_req.paddr == 12'h004 && apb_req.pstrb[0] |=> ctrl_bits == ($past(ctrl_bits) | $past(wd));
    endproperty
    a_set: assert property (p_set) else $error("set alias wrong");
    property p_hold; !acc_wr |=> $stable(ctrl_bits); endproperty
    a_hold: assert property (p_hold) else $error("bits changed without a write");
    property p_changed; $past(reset_n) |-> settings_changed == (ctrl_bits != $past(ctrl_bits)); endproperty
    a_changed: assert property (p_changed) else $error("change pulse wrong");
    property p_ready; apb_req.psel |-> apb_rsp.pready; endproperty
    a_ready: assert property (p_ready) else $error("ready missing");
    cover property (res_en.high_speed_termination_on && res_en.plus_line_pulldown_on && drv);
    cover property (acc_wr && apb_rsp.pslverr);
    cover property (settings_changed ##2 settings_changed);
endmodule : line_term_checker

bind usb_line_termination_decoder line_term_checker chk_u (.clk(clk), .reset_n(reset_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .res_en(res_en), .ctrl_bits(ctrl_bits), .settings_changed(settings_changed));

/* File: tb/link_ctrl_model.sv */
`timescale 1ns/1ns
// ********
// link controller model, apb master
// ********
module link_ctrl_model
    import usb_line_termination_pkg::*;
(
    input wire logic clk, // bus clock
    input wire apb_rsp_type apb_rsp, // answer from the block
    output apb_req_type apb_req // request to the block
);
    initial apb_req = '0;
    // one transfer, entered just after an edge; held until pready is seen
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: s};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    endtask : xfer
    // release; idle lines flip so no stale value looks valid
    task automatic idle(input int n);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        apb_req.paddr <= ~apb_req.paddr;
        apb_req.pwdata <= ~apb_req.pwdata;
        repeat (n) @(posedge clk);
    endtask : idle
endmodule : link_ctrl_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
// ********
// line termination bench
// ********
module tb_top import usb_line_termination_pkg::*;;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    apb_req_type apb_req;
    apb_rsp_type apb_rsp;
    resistor_en_type res_en;
    line_ctrl_type ctrl_bits;
    logic settings_changed;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    logic [44:0] exp_q[$];
    logic [44:0] msk_q[$];
    logic [44:0] act, e, m;
    logic [6:0] ctrl_m = 7'h61;
    logic [15:0] cnt_m = 16'h0000;
    logic pend = 1'b0;
    logic [32:0] cap;
    logic [6:0] rows_c [8] = '{7'h70, 7'h65, 7'h70, 7'h75, 7'h14, 7'h00, 7'h45, 7'h68};
    logic [3:0] rows_r [8] = '{4'hE, 4'h6, 4'hE, 4'h6, 4'h1, 4'h8, 4'h5, 4'h0};

    always #50 clk = ~clk;

    usb_line_termination_decoder dut_u (.clk(clk), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .res_en(res_en), .ctrl_bits(ctrl_bits), .settings_changed(settings_changed));
    link_ctrl_model link_u (.clk(clk), .apb_rsp(apb_rsp), .apb_req(apb_req));

    // expected enables: termination, minus pd, plus pd, pull-up
    function automatic logic [3:0] dec(input logic [6:0] c);
        if (c[4:3] == 2'b01) begin
            return 4'h0;
        end
        return {c[1:0] == 2'b00 && !c[2], c[6], c[5], c[2] && !c[5]};
    endfunction : dec
    // nondriving flag and role for the status word
    function automatic logic [3:0] st(input logic [6:0] c);
        if (c[4:3] == 2'b01) begin
            return 4'h8;
        end
        case (c[6:5])
            2'b11: return 4'h1;
            2'b00: return 4'h2;
            2'b10: return 4'h3;
            default: return 4'h4;
        endcase
    endfunction : st
    // write: note the record, then run the bus cycle
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [6:0] n;
        logic err;
        n = ctrl_m;
        err = !(a == 12'h000 || a == 12'h004 || a == 12'h008);
        if (!err && s[0]) begin
            n = (a == 12'h000) ? d[6:0] : (a == 12'h004) ? (ctrl_m | d[6:0]) : (ctrl_m & ~d[6:0]);
            cnt_m = cnt_m + 16'h0001;
        end
        exp_q.push_back({32'h0, err, n != ctrl_m, dec(n), n});
        msk_q.push_back({32'h0, 13'h1FFF});
        ctrl_m = n;
        link_u.xfer(1'b1, a, d, s);
    endtask : wr
    // read: data is masked when an error is expected
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic err);
        exp_q.push_back({x, err, 1'b0, dec(ctrl_m), ctrl_m});
        msk_q.push_back({err ? 32'h0 : 32'hFFFFFFFF, 13'h1FFF});
        link_u.xfer(1'b0, a, 32'h0, 4'h0);
    endtask : rd
    task automatic results();
        if (exp_q.size() != 0) begin
            err_total++;
        end
        $display("checked %0d, errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // watcher: a completed access is judged one cycle later, after the write lands
    always @(posedge clk) begin
        if (pend) begin
            act = {cap, settings_changed, res_en, ctrl_bits};
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            checked++;
            if ((act & m) !== (e & m)) begin
                err_total++;
                $display("mismatch at %0t: got %h expected %h", $time, act & m, e & m);
            end
        end
        pend = reset_n && apb_req.psel && apb_req.penable && apb_rsp.pready;
        cap = {apb_rsp.prdata, apb_rsp.pslverr};
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end

    initial begin
        void'($urandom(32'hA395));
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(12'h00C, 32'h16, 1'b0);
        for (int i = 0; i < 8; i++) begin
            wr(12'h000, {25'h0, rows_c[i]}, 4'hF);
            rd(12'h00C, {24'h0, st(rows_c[i]), rows_r[i]}, 1'b0);
        end
        // refused accesses and a write without byte lane 0 leave the bits alone
        wr(12'h00C, 32'hFFFFFFFF, 4'hF);
        wr(12'h010, 32'hFFFFFFFF, 4'hF);
        wr(12'h020, 32'h0000007F, 4'hF);
        wr(12'h000, 32'h00000000, 4'hE);
        rd(12'h024, 32'h0, 1'b1);
        // plus request alone: that pull-down and termination, unusual role in status
        wr(12'h000, 32'h00000020, 4'hF);
        rd(12'h00C, 32'h0000004A, 1'b0);
        wr(12'h004, 32'h00000018, 4'hF);
        wr(12'h008, 32'h00000008, 4'hF);
        rd(12'h008, {25'h0, ctrl_m}, 1'b0);
        rd(12'h010, {16'h0, cnt_m}, 1'b0);
        // random traffic, back to back or with gaps
        for (int i = 0; i < 40; i++) begin
            wr(12'(4 * ($urandom % 3)), $urandom, 4'($urandom));
            if ($urandom % 2 == 1) begin
                link_u.idle(1 + $urandom % 3);
            end
        end
        // reset in mid-run restores the power-up bits
        link_u.idle(1);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        ctrl_m = 7'h61;
        cnt_m = 16'h0000;
        @(posedge clk);
        rd(12'h010, 32'h0, 1'b0);
        rd(12'h000, 32'h61, 1'b0);
        link_u.idle(2);
        results();
    end
endmodule : tb_top
